// >>> verilog/decimal_pkg.sv
package decimal_pkg;
    // register byte offsets
    localparam logic [4:0] OFS_CTRL   = 5'h00;
    localparam logic [4:0] OFS_CHAR   = 5'h04;
    localparam logic [4:0] OFS_STATUS = 5'h08;
    localparam logic [4:0] OFS_INDEX  = 5'h0c;
    localparam logic [4:0] OFS_RECOV  = 5'h10;
    localparam logic [4:0] OFS_MODE   = 5'h14;
    // field positions
    localparam int CTRL_OP_LSB    = 0;
    localparam int CTRL_DELIM_LSB = 4;
    localparam int CHAR_A_LSB     = 0;
    localparam int CHAR_C_LSB     = 6;
    localparam int CHAR_AV_BIT    = 12;
    localparam int CHAR_CV_BIT    = 13;
    localparam int CHAR_LAST_BIT  = 14;
    localparam int ST_FAULT_BIT   = 2;
    localparam int MODE_EN_BIT    = 0;
    localparam int MODE_MON_BIT   = 1;
    localparam int REC_NEG_BIT    = 6;
    localparam int REC_AGT_BIT    = 7;
    localparam int REC_CGT_BIT    = 8;
    localparam int REC_ZERO_BIT   = 9;
    localparam int REC_UNLIKE_BIT = 10;
    localparam int REC_CNT_LSB    = 12;
    // values
    localparam logic [1:0]  COND_EQ       = 2'h0;
    localparam logic [1:0]  COND_GT       = 2'h1;
    localparam logic [1:0]  COND_LT       = 2'h2;
    localparam logic [23:0] REC_RESET     = 24'h000000;
    localparam logic [11:0] CNT_ZERO      = 12'h000;
    localparam logic [11:0] CNT_ONE       = 12'h001;
    localparam logic [3:0]  NUM_MAX       = 4'h9;
    localparam logic [3:0]  NUM_SIGN_ZERO = 4'ha;
    localparam logic [5:0]  SIGN_BAD      = 6'h3a;
    localparam logic [1:0]  ZONE_NEG      = 2'h2;
    localparam logic [1:0]  ZONE_NONE     = 2'h0;

    typedef enum logic [2:0] {
        OP_DELIM, OP_NUMCMP, OP_SIGN, OP_NUMTEST, OP_LOADREC, OP_STOREREC
    } op_t;
    typedef enum logic [1:0] {ST_IDLE, ST_RUN, ST_FIN} state_t;
endpackage

// >>> verilog/screen_if.sv
`timescale 1ns/1ns
interface screen_if;
    logic [5:0] ch;
    logic       is_sign;
    logic [3:0] num;
    logic       bad;
    logic       nonzero;
    logic       neg;
    modport src (output ch, output is_sign, input num, input bad, input nonzero, input neg);
    modport scr (input ch, input is_sign, output num, output bad, output nonzero, output neg);
endinterface

// >>> verilog/char_screen.sv
`timescale 1ns/1ns
module char_screen import decimal_pkg::*; (
    screen_if.scr s
);
    logic [1:0] zone;
    logic [3:0] raw;
    logic       sign_zero;

    // classify one character; the sign character follows its own legality
    always_comb begin
        zone = s.ch[5:4];
        raw = s.ch[3:0];
        s.num = (raw > NUM_MAX) ? 4'h0 : raw; // illegal digit ranks as zero [RULE8]
        sign_zero = (raw == 4'h0) || (raw == NUM_SIGN_ZERO && s.ch != SIGN_BAD); // [RULE12]
        if (s.is_sign) begin
            s.bad = (raw > NUM_MAX && raw != NUM_SIGN_ZERO) || s.ch == SIGN_BAD; // [RULE9]
            s.nonzero = !sign_zero && (s.num != 4'h0 || raw == NUM_SIGN_ZERO); // [RULE8]
        end else begin
            s.bad = (zone != ZONE_NONE) || (raw > NUM_MAX); // [RULE9]
            s.nonzero = (s.num != 4'h0);
        end
        s.neg = s.is_sign && (zone == ZONE_NEG); // [RULE13]
    end
endmodule

// >>> verilog/cond_resolve.sv
`timescale 1ns/1ns
module cond_resolve import decimal_pkg::*; (
    input  wire logic [1:0] rel,
    input  wire logic       a_nz,
    input  wire logic       c_nz,
    input  wire logic       a_neg,
    input  wire logic       c_neg,
    output logic      [1:0] num_cond,
    output logic      [1:0] test_cond
);
    logic an;
    logic cn;

    // signed ranking; a zero of either sign counts as positive
    always_comb begin
        an = a_neg && a_nz; // [RULE7]
        cn = c_neg && c_nz;
        if (!a_nz && !c_nz) begin
            num_cond = COND_EQ; // [RULE7]
        end else if (an != cn) begin
            num_cond = an ? COND_LT : COND_GT; // [RULE7]
        end else if (an && rel != COND_EQ) begin
            num_cond = (rel == COND_GT) ? COND_LT : COND_GT; // larger negative ranks lower
        end else begin
            num_cond = rel; // [RULE5]
        end
        test_cond = !a_nz ? COND_EQ : (a_neg ? COND_LT : COND_GT); // [RULE12] [RULE13]
    end
endmodule

// >>> verilog/decimal_field_compare_test_unit.sv
// What this block does
// RULE1 - delimited compare leaves processed count in index
// RULE2 - delimited compare sets equal, greater, less code
// RULE3 - numeric compare runs low to high, excess versus zero
// RULE4 - unequal resumes third word, equal fourth word
// RULE5 - numeric compare sets equal, greater, less code
// RULE6 - unlike signs clear index, else C count
// RULE7 - positive beats negative, plus and minus zero equal
// RULE8 - only numeric nibble compared, illegal becomes zero
// RULE9 - fault on zone, bad digit, bad sign
// RULE10 - fault never stops the instruction
// RULE11 - sign test stops at first nonzero or count
// RULE12 - zero field with zero sign gives equal
// RULE13 - nonzero field: sign zone picks greater or less
// RULE14 - sign and numeric tests clear the index
// RULE15 - numeric test scans whole field, fault flags non-numeric
// RULE16 - caller zeroes unused instruction word bits
// RULE17 - load recovery takes condition and state from word
// RULE18 - recovery word layout of condition, flags, count
// RULE19 - load recovery traps when disabled, monitor no-op
// RULE20 - software stores state after interrupt, reloads before restart
// RULE21 - store recovery copies state without clearing it
// RULE22 - store recovery traps when disabled, monitor no-op
// RULE23 - condition holds until next writer
//
// Local design decisions: the address map and the Avalon-MM register port.
`timescale 1ns/1ns
module decimal_field_compare_test_unit import decimal_pkg::*; (
    input  wire logic        MCLK,
    input  wire logic        RESET_N,
    input  wire logic [4:0]  AVS_ADDRESS,
    input  wire logic        AVS_READ,
    input  wire logic        AVS_WRITE,
    input  wire logic [31:0] AVS_WRITEDATA,
    input  wire logic [3:0]  AVS_BYTEENABLE,
    output logic      [31:0] AVS_READDATA,
    output logic             AVS_WAITREQUEST,
    output logic      [1:0]  RESULT_COND,
    output logic             DECIMAL_FAULT,
    output logic      [11:0] INDEX3,
    output logic             NEXT_AT_P4,
    output logic             TRAP_REQ
);
    // bus group
    logic        wait_q;
    logic        wait_d;
    logic [31:0] rdata_q;
    logic [31:0] rdata_d;
    logic [31:0] rmux;
    // engine group
    state_t      st_q;
    state_t      st_d;
    op_t         op_q;
    op_t         op_d;
    op_t         req_op;
    logic [5:0]  delim_q;
    logic [5:0]  delim_d;
    logic [23:0] rec_q;
    logic [23:0] rec_d;
    logic [23:0] recin_q;
    logic [23:0] recin_d;
    logic [23:0] recout_q;
    logic [23:0] recout_d;
    logic [11:0] cnt_q;
    logic [11:0] cnt_d;
    logic [11:0] idx3_q;
    logic [11:0] idx3_d;
    logic [1:0]  rel_q;
    logic [1:0]  rel_d;
    logic        fault_q;
    logic        fault_d;
    logic        anz_q;
    logic        anz_d;
    logic        cnz_q;
    logic        cnz_d;
    logic        aneg_q;
    logic        aneg_d;
    logic        cneg_q;
    logic        cneg_d;
    logic        seena_q;
    logic        seena_d;
    logic        seenc_q;
    logic        seenc_d;
    logic        stop_q;
    logic        stop_d;
    logic        skip_q;
    logic        skip_d;
    logic        trap_q;
    logic        trap_d;
    logic        trapped_q;
    logic        trapped_d;
    logic        en_q;
    logic        en_d;
    logic        mon_q;
    logic        mon_d;
    // decoded strobes and character fields
    logic        wr;
    logic        ctrl_wr;
    logic        char_wr;
    logic        stat_wr;
    logic        mode_wr;
    logic        recin_wr;
    logic        fault_set;
    logic [5:0]  ca;
    logic [5:0]  cc;
    logic        av;
    logic        cv;
    logic [3:0]  na;
    logic [3:0]  nc;
    logic [1:0]  num_cond;
    logic [1:0]  test_cond;

    // word-aligned decode, shared by the read and write paths
    function automatic logic hit(input logic [4:0] a, input logic [4:0] ofs);
        return a[4:2] == ofs[4:2];
    endfunction

    screen_if sa_if ();
    screen_if sc_if ();

    char_screen u_screen_a (
        .s (sa_if.scr)
    );
    char_screen u_screen_c (
        .s (sc_if.scr)
    );
    cond_resolve u_resolve (
        .rel       (rel_q),
        .a_nz      (anz_q),
        .c_nz      (cnz_q),
        .a_neg     (aneg_q),
        .c_neg     (cneg_q),
        .num_cond  (num_cond),
        .test_cond (test_cond)
    );

    // partial-word writes are dropped: several fields straddle byte lanes
    assign wr       = AVS_WRITE && !wait_q && (AVS_BYTEENABLE == 4'hf);
    assign ctrl_wr  = wr && hit(AVS_ADDRESS, OFS_CTRL);
    assign char_wr  = wr && hit(AVS_ADDRESS, OFS_CHAR);
    assign stat_wr  = wr && hit(AVS_ADDRESS, OFS_STATUS);
    assign mode_wr  = wr && hit(AVS_ADDRESS, OFS_MODE);
    assign recin_wr = wr && hit(AVS_ADDRESS, OFS_RECOV);
    assign req_op   = op_t'(AVS_WRITEDATA[CTRL_OP_LSB +: 3]);
    assign ca       = AVS_WRITEDATA[CHAR_A_LSB +: 6];
    assign cc       = AVS_WRITEDATA[CHAR_C_LSB +: 6];
    assign av       = AVS_WRITEDATA[CHAR_AV_BIT];
    assign cv       = AVS_WRITEDATA[CHAR_CV_BIT];
    assign sa_if.ch      = ca;
    assign sa_if.is_sign = !seena_q;
    assign sc_if.ch      = cc;
    assign sc_if.is_sign = !seenc_q;
    assign na = av ? sa_if.num : 4'h0; // a missing digit compares as zero [RULE3]
    assign nc = cv ? sc_if.num : 4'h0;

    // read mux; unmapped words read as zero
    always_comb begin
        rmux = 32'h0;
        if (hit(AVS_ADDRESS, OFS_CTRL)) begin
            rmux = {22'h0, delim_q, 1'b0, op_q};
        end else if (hit(AVS_ADDRESS, OFS_STATUS)) begin
            rmux = {26'h0, skip_q, trapped_q, st_q != ST_IDLE, fault_q, rec_q[1:0]};
        end else if (hit(AVS_ADDRESS, OFS_INDEX)) begin
            rmux = {20'h0, idx3_q};
        end else if (hit(AVS_ADDRESS, OFS_RECOV)) begin
            rmux = {8'h0, recout_q};
        end else if (hit(AVS_ADDRESS, OFS_MODE)) begin
            rmux = {30'h0, mon_q, en_q};
        end
    end

    // one wait cycle per access, then a single low cycle that completes it
    always_comb begin
        wait_d = !((AVS_READ || AVS_WRITE) && wait_q);
        rdata_d = rdata_q;
        if (AVS_READ && wait_q) begin
            rdata_d = rmux;
        end
    end

    always_ff @(posedge MCLK) begin
        if (!RESET_N) begin
            wait_q  <= 1'b1;
            rdata_q <= 32'h0;
        end else begin
            wait_q  <= wait_d;
            rdata_q <= rdata_d;
        end
    end

    // engine next state
    always_comb begin
        st_d = st_q;
        op_d = op_q;
        delim_d = delim_q;
        rec_d = rec_q; // condition holds between writers [RULE23]
        recin_d = recin_q;
        recout_d = recout_q;
        cnt_d = cnt_q;
        idx3_d = idx3_q;
        rel_d = rel_q;
        anz_d = anz_q;
        cnz_d = cnz_q;
        aneg_d = aneg_q;
        cneg_d = cneg_q;
        seena_d = seena_q;
        seenc_d = seenc_q;
        stop_d = stop_q;
        skip_d = skip_q;
        trap_d = 1'b0;
        trapped_d = trapped_q;
        en_d = en_q;
        mon_d = mon_q;
        fault_set = 1'b0;
        if (mode_wr) begin
            en_d = AVS_WRITEDATA[MODE_EN_BIT];
            mon_d = AVS_WRITEDATA[MODE_MON_BIT];
        end
        if (recin_wr) begin
            recin_d = AVS_WRITEDATA[23:0];
        end
        unique case (st_q)
            ST_IDLE: begin
                if (ctrl_wr) begin
                    trapped_d = 1'b0;
                    unique case (req_op)
                        OP_LOADREC: begin
                            if (!en_q) begin
                                trap_d = !mon_q; // monitor state makes it a no-op [RULE19]
                                trapped_d = !mon_q;
                            end else begin
                                rec_d = recin_q; // whole word, layout kept [RULE17] [RULE18]
                            end
                        end
                        OP_STOREREC: begin
                            if (!en_q) begin
                                trap_d = !mon_q; // [RULE22]
                                trapped_d = !mon_q;
                            end else begin
                                recout_d = rec_q; // live state stays untouched [RULE21]
                            end
                        end
                        OP_DELIM, OP_NUMCMP, OP_SIGN, OP_NUMTEST: begin
                            op_d = req_op;
                            delim_d = AVS_WRITEDATA[CTRL_DELIM_LSB +: 6];
                            rec_d[23:REC_CNT_LSB] = CNT_ZERO;
                            cnt_d = CNT_ZERO;
                            rel_d = COND_EQ;
                            {anz_d, cnz_d, aneg_d, cneg_d} = 4'h0;
                            {seena_d, seenc_d, stop_d} = 3'h0;
                            st_d = ST_RUN;
                        end
                        default: begin
                        end
                    endcase
                end
            end
            ST_RUN: begin
                if (char_wr) begin
                    unique case (op_q)
                        OP_DELIM: begin
                            if (!stop_q) begin
                                cnt_d = cnt_q + CNT_ONE;
                                rec_d[23:REC_CNT_LSB] = rec_q[23:REC_CNT_LSB] + CNT_ONE;
                                if (ca == delim_q || cc == delim_q) begin
                                    stop_d = 1'b1; // equal through delimiter [RULE2]
                                end else if (ca != cc) begin
                                    stop_d = 1'b1;
                                    rel_d = (ca > cc) ? COND_GT : COND_LT; // [RULE2]
                                end
                            end
                        end
                        OP_NUMCMP: begin
                            if (av) begin
                                rec_d[23:REC_CNT_LSB] = rec_q[23:REC_CNT_LSB] + CNT_ONE;
                                seena_d = 1'b1;
                                fault_set = sa_if.bad;
                                anz_d = anz_q || sa_if.nonzero;
                                if (!seena_q) begin
                                    aneg_d = sa_if.neg;
                                end
                            end
                            if (cv) begin
                                cnt_d = cnt_q + CNT_ONE;
                                seenc_d = 1'b1;
                                fault_set = fault_set || sc_if.bad;
                                cnz_d = cnz_q || sc_if.nonzero;
                                if (!seenc_q) begin
                                    cneg_d = sc_if.neg;
                                end
                            end
                            // a higher-order difference overrides lower ones [RULE3] [RULE8]
                            if (na > nc) begin
                                rel_d = COND_GT;
                            end else if (na < nc) begin
                                rel_d = COND_LT;
                            end
                        end
                        OP_SIGN, OP_NUMTEST: begin
                            if (av && !stop_q) begin
                                rec_d[23:REC_CNT_LSB] = rec_q[23:REC_CNT_LSB] + CNT_ONE;
                                seena_d = 1'b1;
                                fault_set = sa_if.bad;
                                anz_d = anz_q || sa_if.nonzero; // [RULE15]
                                if (!seena_q) begin
                                    aneg_d = sa_if.neg;
                                end
                                stop_d = (op_q == OP_SIGN) && sa_if.nonzero; // [RULE11]
                            end
                        end
                        default: begin
                        end
                    endcase
                    // a fault never ends the scan early [RULE10]
                    if (AVS_WRITEDATA[CHAR_LAST_BIT]) begin
                        st_d = ST_FIN;
                    end
                end
            end
            ST_FIN: begin
                st_d = ST_IDLE;
                unique case (op_q)
                    OP_DELIM: begin
                        rec_d[1:0] = rel_q; // [RULE2]
                        idx3_d = cnt_q; // [RULE1]
                        skip_d = (rel_q == COND_EQ); // [RULE4]
                    end
                    OP_NUMCMP: begin
                        rec_d[1:0] = num_cond; // [RULE5]
                        skip_d = (num_cond == COND_EQ); // [RULE4]
                        idx3_d = (aneg_q != cneg_q) ? CNT_ZERO : cnt_q; // [RULE6]
                        rec_d[REC_NEG_BIT] = aneg_q && anz_q;
                        rec_d[REC_AGT_BIT] = (num_cond == COND_GT);
                        rec_d[REC_CGT_BIT] = (num_cond == COND_LT);
                        rec_d[REC_ZERO_BIT] = !anz_q;
                        rec_d[REC_UNLIKE_BIT] = (aneg_q != cneg_q);
                    end
                    default: begin
                        rec_d[1:0] = test_cond; // [RULE12] [RULE13]
                        idx3_d = CNT_ZERO; // [RULE14]
                    end
                endcase
            end
        endcase
        // hardware set wins over a software clear in the same cycle
        fault_d = (fault_q && !(stat_wr && AVS_WRITEDATA[ST_FAULT_BIT])) || fault_set; // [RULE9]
    end

    always_ff @(posedge MCLK) begin
        if (!RESET_N) begin
            st_q      <= ST_IDLE;
            op_q      <= OP_DELIM;
            delim_q   <= 6'h0;
            rec_q     <= REC_RESET;
            recin_q   <= REC_RESET;
            recout_q  <= REC_RESET;
            cnt_q     <= CNT_ZERO;
            idx3_q    <= CNT_ZERO;
            rel_q     <= COND_EQ;
            fault_q   <= 1'b0;
            {anz_q, cnz_q, aneg_q, cneg_q} <= 4'h0;
            {seena_q, seenc_q, stop_q}     <= 3'h0;
            skip_q    <= 1'b0;
            trap_q    <= 1'b0;
            trapped_q <= 1'b0;
            en_q      <= 1'b0;
            mon_q     <= 1'b0;
        end else begin
            st_q      <= st_d;
            op_q      <= op_d;
            delim_q   <= delim_d;
            rec_q     <= rec_d;
            recin_q   <= recin_d;
            recout_q  <= recout_d;
            cnt_q     <= cnt_d;
            idx3_q    <= idx3_d;
            rel_q     <= rel_d;
            fault_q   <= fault_d;
            {anz_q, cnz_q, aneg_q, cneg_q} <= {anz_d, cnz_d, aneg_d, cneg_d};
            {seena_q, seenc_q, stop_q}     <= {seena_d, seenc_d, stop_d};
            skip_q    <= skip_d;
            trap_q    <= trap_d;
            trapped_q <= trapped_d;
            en_q      <= en_d;
            mon_q     <= mon_d;
        end
    end

    // outputs straight from flip-flops
    assign AVS_READDATA    = rdata_q;
    assign AVS_WAITREQUEST = wait_q;
    assign RESULT_COND     = rec_q[1:0];
    assign DECIMAL_FAULT   = fault_q;
    assign INDEX3          = idx3_q;
    assign NEXT_AT_P4      = skip_q;
    assign TRAP_REQ        = trap_q;

    default clocking cb @(posedge MCLK); endclocking
    default disable iff (!RESET_N);

    sequence s_num_fin;
        st_q == ST_FIN && op_q == OP_NUMCMP;
    endsequence
    sequence s_test_fin;
        st_q == ST_FIN && (op_q == OP_SIGN || op_q == OP_NUMTEST);
    endsequence

    a_delim_count: assert property (st_q == ST_FIN && op_q == OP_DELIM // [RULE1]
        |=> idx3_q == $past(cnt_q))
        else $error("delimited count not in index");
    a_delim_equal: assert property (st_q == ST_FIN && op_q == OP_DELIM && !stop_q
        |=> RESULT_COND == COND_EQ) // [RULE2]
        else $error("delimited compare to end not equal");
    a_excess_zero: assert property (st_q == ST_RUN && char_wr && op_q == OP_NUMCMP // [RULE3]
        && av && !cv && sa_if.num != 4'h0 |=> rel_q == COND_GT)
        else $error("excess digit not ranked against zero");
    a_skip_equal: assert property (s_num_fin |=> NEXT_AT_P4 == (RESULT_COND == COND_EQ)) // [RULE4]
        else $error("next-instruction choice wrong");
    a_unlike_clear: assert property (s_num_fin ##0 aneg_q != cneg_q // [RULE6]
        |=> INDEX3 == CNT_ZERO)
        else $error("unlike signs left a count");
    a_zero_equal: assert property (s_num_fin ##0 !anz_q && !cnz_q // [RULE7]
        |=> RESULT_COND == COND_EQ)
        else $error("plus and minus zero unequal");
    a_fault_raise: assert property (st_q == ST_RUN && char_wr && op_q == OP_NUMTEST // [RULE9]
        && av && sa_if.bad |=> DECIMAL_FAULT)
        else $error("bad character raised no fault");
    a_fault_runon: assert property (st_q == ST_RUN && fault_q && char_wr // [RULE10]
        && !AVS_WRITEDATA[CHAR_LAST_BIT] |=> st_q == ST_RUN)
        else $error("fault stopped the scan");
    a_test_index: assert property (s_test_fin // [RULE14]
        |=> INDEX3 == CNT_ZERO && st_q == ST_IDLE)
        else $error("test left a count");
    a_load_trap: assert property (st_q == ST_IDLE && ctrl_wr // [RULE19]
        && req_op == OP_LOADREC && !en_q
        |=> TRAP_REQ == !$past(mon_q) && $stable(RESULT_COND))
        else $error("disabled load did not trap or altered state");
    a_store_keep: assert property (st_q == ST_IDLE && ctrl_wr // [RULE21]
        && req_op == OP_STOREREC && en_q
        |=> recout_q == $past(rec_q) && $stable(rec_q))
        else $error("store altered or missed state");
endmodule

// >>> bench/seq_master.sv
`timescale 1ns/1ns
// stands in for the instruction sequencer as bus master
module seq_master (
    input  wire logic        clk,
    input  wire logic        waitreq,
    input  wire logic [31:0] rdata,
    output logic      [4:0]  addr,
    output logic             rd,
    output logic             wr,
    output logic      [31:0] wdata,
    output logic      [3:0]  be
);
    initial begin
        {addr, rd, wr, wdata} = '0;
        be = 4'hf;
    end
    // raise one edge after the last release, so no signal is assigned twice in a step
    task automatic xfer(input logic w, input logic [4:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        int n;
        n = 0;
        @(posedge clk);
        addr <= a;
        wr <= w;
        rd <= ~w;
        wdata <= d;
        do begin
            @(posedge clk);
            n++;
        end while (waitreq !== 1'b0 && n < 40);
        q = rdata;
        wr <= 1'b0;
        rd <= 1'b0;
        if (waitreq !== 1'b0) begin
            tb_top.num_errors++;
            tb_top.conclude();
        end
    endtask
endmodule

// >>> bench/tb_top.sv
`timescale 1ns/1ns
`define CHK(g, e) begin n_checks++; if ((g) !== (e)) begin num_errors++; \
    $display("ERROR %0t got %0h exp %0h", $time, g, e); end end
module tb_top import decimal_pkg::*;
;
    logic        MCLK = 1'b0;
    logic        RESET_N = 1'b0;
    logic        rd, wr, wq, p4, trap, fault;
    logic [1:0]  cond;
    logic [3:0]  be;
    logic [4:0]  addr;
    logic [11:0] idx;
    logic [31:0] wdata, rdata, q;
    int          num_errors = 0;
    int          n_checks = 0;
    int          traps = 0;
    always #2 MCLK = ~MCLK;
    // trap is a one-cycle pulse, so tally it as it passes
    always @(posedge MCLK) if (trap === 1'b1) traps++;
    decimal_field_compare_test_unit decimal_field_compare_test_unit_inst (
        .MCLK(MCLK), .RESET_N(RESET_N), .AVS_ADDRESS(addr), .AVS_READ(rd), .AVS_WRITE(wr),
        .AVS_WRITEDATA(wdata), .AVS_BYTEENABLE(be), .AVS_READDATA(rdata),
        .AVS_WAITREQUEST(wq), .RESULT_COND(cond), .DECIMAL_FAULT(fault), .INDEX3(idx),
        .NEXT_AT_P4(p4), .TRAP_REQ(trap));
    seq_master seq_master_inst (.clk(MCLK), .waitreq(wq), .rdata(rdata), .addr(addr),
        .rd(rd), .wr(wr), .wdata(wdata), .be(be));
    function automatic logic [13:0] pr(input logic [5:0] a, input logic [5:0] c);
        return {2'b11, c, a};
    endfunction
    function automatic logic [13:0] ao(input logic [5:0] a);
        return {2'b01, 6'h00, a};
    endfunction
    task automatic wr32(input logic [4:0] a, input logic [31:0] d);
        logic [31:0] x;
        seq_master_inst.xfer(1'b1, a, d, x);
    endtask
    // start an op, feed one pair per write, then poll busy; ports are settled once idle
    task automatic run(input logic [31:0] ctl, input logic [13:0] ch[$]);
        wr32(OFS_CTRL, ctl);
        foreach (ch[i]) wr32(OFS_CHAR, {17'h0, i == ch.size() - 1, ch[i]});
        for (int n = 0; n < 9 && q[3] !== 1'b0; n++) seq_master_inst.xfer(0, OFS_STATUS, 0, q);
        `CHK(q[3], 1'b0)
        if (q[3] !== 1'b0) conclude(); // a hung run ends the bench
        q[3] = 1'b1;
    endtask
    task automatic t_delim;
        run({22'h0, 6'h3f, 4'h0}, {pr(6'h01, 6'h01), pr(6'h02, 6'h03)});
        `CHK(cond, COND_LT)
        `CHK(idx, 12'h002)
        `CHK(p4, 1'b0)
        // delimiter in A ends it equal; the pair after it is ignored
        run({22'h0, 6'h07, 4'h0}, {pr(6'h01, 6'h01), pr(6'h07, 6'h05), pr(6'h02, 6'h03)});
        `CHK(cond, COND_EQ)
        `CHK(idx, 12'h002)
        `CHK(p4, 1'b1)
        run({22'h0, 6'h3f, 4'h0}, {pr(6'h04, 6'h04)});
        `CHK(cond, COND_EQ)
        `CHK(idx, CNT_ONE)
        $display("delimited compare done");
    endtask
    // sign test stops at the nonzero sign, so the bad zone above it is never seen
    task automatic t_tests;
        run(32'h2, {ao(6'h23), ao(6'h15)}); // unused bits zero
        `CHK(cond, COND_LT)
        `CHK(fault, 1'b0)
        `CHK(idx, CNT_ZERO)
        run(32'h2, {ao(6'h30)});
        `CHK(cond, COND_EQ)
        run(32'h3, {ao(6'h13), ao(6'h15)});
        `CHK(cond, COND_GT)
        `CHK(fault, 1'b1)
        wr32(OFS_STATUS, 32'h4);
        $display("field tests done");
    endtask
    task automatic t_numeric;
        run(32'h1, {pr(6'h05, 6'h05), ao(6'h00)});
        `CHK(cond, COND_EQ)
        `CHK(p4, 1'b1)
        `CHK(idx, CNT_ONE)
        // excess A digit ranks against zero
        run(32'h1, {pr(6'h05, 6'h05), ao(6'h01)});
        `CHK(cond, COND_GT)
        `CHK(p4, 1'b0)
        `CHK(idx, CNT_ONE)
        `CHK(fault, 1'b0)
        run(32'h1, {pr(6'h05, 6'h23)});
        `CHK(cond, COND_GT)
        `CHK(idx, CNT_ZERO)
        `CHK(p4, 1'b0)
        run(32'h1, {pr(6'h00, 6'h20)});
        `CHK(cond, COND_EQ)
        run(32'h1, {pr(6'h0b, 6'h00), pr(6'h11, 6'h00)});
        `CHK(cond, COND_GT)
        `CHK(fault, 1'b1)
        $display("numeric compare done");
    endtask
    // disabled traps, monitor swallows quietly, enabled load and store round-trip
    task automatic t_recov;
        wr32(OFS_MODE, 32'h0);
        wr32(OFS_CTRL, 32'h4);
        wr32(OFS_CTRL, 32'h5);
        seq_master_inst.xfer(0, OFS_STATUS, 0, q);
        `CHK(q[4], 1'b1)
        wr32(OFS_MODE, 32'h2);
        wr32(OFS_CTRL, 32'h4);
        seq_master_inst.xfer(0, OFS_STATUS, 0, q);
        `CHK(traps, 1 + 1)
        `CHK(q[4], 1'b0)
        wr32(OFS_MODE, 32'h1);
        wr32(OFS_RECOV, 32'h3402);
        wr32(OFS_CTRL, 32'h4);
        wr32(OFS_CTRL, 32'h5);
        seq_master_inst.xfer(0, OFS_RECOV, 0, q);
        `CHK(q[23:0], 24'h003402)
        `CHK(cond, COND_LT)
        $display("recovery done");
    endtask
    task automatic conclude;
        $display("checks %0d errors %0d", n_checks, num_errors);
        if (num_errors == 0 && n_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    initial begin
        q = 32'h8;
        repeat (8) @(posedge MCLK);
        RESET_N <= 1'b1;
        t_delim();
        t_tests();
        t_numeric();
        t_recov();
        conclude();
    end
endmodule
